// [ctl_pkg.sv]
// Shared constants, state codes and carrier types of the bus port control.
package ctl_pkg;

	// Register offsets on the serial bus.
	localparam logic [7:0]  PIN_EN_OFS     = 8'h1C;
	localparam logic [7:0]  PIN_POL_OFS    = 8'h1D;
	localparam logic [7:0]  CTL_OFS        = 8'h1E;
	localparam logic [7:0]  THR_OFS        = 8'h1F;
	localparam logic [7:0]  STATUS_OFS     = 8'h40;
	localparam logic [7:0]  FIFO_DATA_OFS  = 8'h41;

	// Values after reset, and the default device address.
	localparam logic [12:0] CTL_RST        = 13'h0001;
	localparam logic [3:0]  THR_RST        = 4'h0;
	localparam logic [15:0] PIN_EN_RST     = 16'h2090;
	localparam logic        PIN_POL_RST    = 1'b0;
	localparam logic [6:0]  DEV_ADDR_DEF   = 7'h2A;

	// Field positions and widths.
	localparam int CTL_W            = 13;
	localparam int CTL_ADDR_IRQ_BIT = 1;
	localparam int CTL_RS_IRQ_BIT   = 2;
	localparam int CTL_NACK_BIT     = 3;
	localparam int CTL_STOP_IRQ_BIT = 4;
	localparam int CTL_TXREQ_BIT    = 6;
	localparam int CTL_FIFO_HI_BIT  = 7;
	localparam int CTL_WR_LO_BIT    = 10;
	localparam int CTL_SPEED_BIT    = 12;
	localparam int THR_LSB          = 8;
	localparam int THR_W            = 4;
	localparam int PIN_OE_BIT       = 2;
	localparam int PIN_PMOS_OFF_BIT = 15;
	localparam int PIN_POL_BIT      = 5;
	localparam int STS_ADDR_BIT     = 0;
	localparam int STS_RS_BIT       = 1;
	localparam int STS_STOP_BIT     = 2;
	localparam int STS_TXREQ_BIT    = 3;
	localparam int STS_LEVEL_BIT    = 4;
	localparam int STS_W            = 5;

	// Bit counter marks within one byte slot.
	localparam logic [3:0]  CNT_DATA_DONE  = 4'h8;
	localparam logic [3:0]  CNT_ACK_DONE   = 4'h9;

	// Sample stream and FIFO.
	localparam int WORD_W          = 16;
	localparam int FIFO_DEPTH_DEF  = 16;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_ADDR   = 3'b001,
		ST_WRITE  = 3'b010,
		ST_READ   = 3'b011,
		ST_IGNORE = 3'b100
	} bus_state_t;

	typedef struct packed {
		logic              valid;
		logic [WORD_W-1:0] data;
	} word_beat_t;

	typedef struct packed {
		logic out;
		logic drive_n;
	} pin_drive_t;

endpackage

// [bus_port_control.sv]
// Serial bus slave port with control, interrupt and sample FIFO logic.

// Word FIFO with valid and ready on both sides.
module word_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 16
) (
	input  wire logic                       clk,
	input  wire logic                       srst,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	input  wire logic [W-1:0]               in_data,
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [W-1:0]                    out_data,
	output logic [$clog2(DEPTH+1)-1:0]      level
);
	localparam int AW = $clog2(DEPTH);
	localparam int LW = $clog2(DEPTH+1);
	typedef struct packed {
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [LW-1:0] count;
	} fifo_state_t;
	fifo_state_t   cur_ff;
	fifo_state_t   nxt_cur;
	logic [W-1:0]  mem [DEPTH];
	logic          push;
	logic          pop;
	assign in_ready  = (cur_ff.count != LW'(DEPTH));
	assign out_valid = (cur_ff.count != '0);
	assign out_data  = mem[cur_ff.rd_ptr];
	assign level     = cur_ff.count;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	always_comb begin
		nxt_cur = cur_ff;
		if (push) begin
			nxt_cur.wr_ptr = (cur_ff.wr_ptr == AW'(DEPTH-1)) ? '0
				: cur_ff.wr_ptr + 1'b1;
		end
		if (pop) begin
			nxt_cur.rd_ptr = (cur_ff.rd_ptr == AW'(DEPTH-1)) ? '0
				: cur_ff.rd_ptr + 1'b1;
		end
		nxt_cur.count = cur_ff.count + LW'(push) - LW'(pop);
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
		if (push) begin
			mem[cur_ff.wr_ptr] <= in_data;
		end
	end
endmodule
// Top of the bus port: slave engine, registers, interrupt pin and stream.
module bus_port_control
#(
	parameter logic [6:0] DEV_ADDR   = ctl_pkg::DEV_ADDR_DEF,
	parameter int         FIFO_DEPTH = ctl_pkg::FIFO_DEPTH_DEF
) (
	input  wire logic                clk,
	input  wire logic                srst,
	input  wire logic                scl_in,
	input  wire logic                sda_in,
	output ctl_pkg::pin_drive_t      sda_pin,
	output ctl_pkg::pin_drive_t      int_pin,
	output logic                     hs_mode,
	input  wire logic                smp_clk,
	input  wire logic                smp_srst,
	input  ctl_pkg::word_beat_t      smp_in,
	output logic                     smp_ready
);
	import ctl_pkg::*;
	localparam int LW = $clog2(FIFO_DEPTH+1);
	typedef struct packed {
		logic              scl_m;
		logic              scl_s;
		logic              scl_d;
		logic              sda_m;
		logic              sda_s;
		logic              sda_d;
		bus_state_t        st;
		logic [3:0]        cnt;
		logic [7:0]        rx_sh;
		logic [7:0]        tx_sh;
		logic              rw;
		logic              addressed;
		logic              rs_pend;
		logic              mst_ack;
		logic              ptr_valid;
		logic [7:0]        ptr;
		logic              have_first;
		logic [7:0]        first_byte;
		logic              rd_half;
		logic [15:0]       rd_word;
		logic [CTL_W-1:0]  ctl;
		logic [THR_W-1:0]  thr;
		logic [15:0]       pin_en;
		logic              pin_pol;
		logic [2:0]        sticky;
		logic              req_m;
		logic              req_s;
		logic              ack_tgl;
		pin_drive_t        sda_drv;
		pin_drive_t        int_drv;
		logic              hs;
	} core_t;
	typedef struct packed {
		logic [WORD_W-1:0] hold;
		logic              req_tgl;
		logic              ack_m;
		logic              ack_s;
		logic              ready;
	} link_t;
	core_t              core_ff;
	core_t              nxt_core;
	link_t              link_ff;
	link_t              nxt_link;
	logic               fifo_in_ready;
	logic               fifo_out_valid;
	logic               fifo_pop;
	logic [WORD_W-1:0]  fifo_out_data;
	logic [LW-1:0]      fifo_level;
	logic               push_pending;
	assign push_pending = (core_ff.req_s != core_ff.ack_tgl);
	word_fifo #(
		.W     (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.srst      (srst),
		.in_valid  (push_pending),
		.in_ready  (fifo_in_ready),
		.in_data   (link_ff.hold),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data),
		.level     (fifo_level)
	);
	// Sample side: a word is held stable until the core domain returns
	// the toggle, so only the toggle needs a synchroniser.
	always_comb begin
		nxt_link       = link_ff;
		nxt_link.ack_m = core_ff.ack_tgl;
		nxt_link.ack_s = link_ff.ack_m;
		if (smp_in.valid && link_ff.ready) begin
			nxt_link.hold    = smp_in.data;
			nxt_link.req_tgl = ~link_ff.req_tgl;
		end
		nxt_link.ready = (nxt_link.req_tgl == nxt_link.ack_s);
	end
	always_ff @(posedge smp_clk) begin
		if (smp_srst) begin
			link_ff <= '0;
		end else begin
			link_ff <= nxt_link;
		end
	end
	logic              rise;
	logic              fall;
	logic              start_c;
	logic              stop_c;
	logic              addr_hit;
	logic [15:0]       wr_word;
	logic [15:0]       rd_val;
	logic              txreq_lvl;
	logic              level_lvl;
	logic [STS_W-1:0]  sts;
	logic [STS_W-1:0]  en;
	logic [2:0]        sticky_set;
	logic [2:0]        sticky_clr;
	logic              irq;
	logic              load_rd;
	always_comb begin
		nxt_core       = core_ff;
		nxt_core.scl_m = scl_in;
		nxt_core.scl_s = core_ff.scl_m;
		nxt_core.scl_d = core_ff.scl_s;
		nxt_core.sda_m = sda_in;
		nxt_core.sda_s = core_ff.sda_m;
		nxt_core.sda_d = core_ff.sda_s;
		nxt_core.req_m = link_ff.req_tgl;
		nxt_core.req_s = core_ff.req_m;
		if (push_pending && fifo_in_ready) begin
			nxt_core.ack_tgl = ~core_ff.ack_tgl;
		end
		rise    = core_ff.scl_s && !core_ff.scl_d;
		fall    = !core_ff.scl_s && core_ff.scl_d;
		start_c = core_ff.scl_s && core_ff.scl_d
			&& core_ff.sda_d && !core_ff.sda_s;
		stop_c  = core_ff.scl_s && core_ff.scl_d
			&& !core_ff.sda_d && core_ff.sda_s;
		addr_hit   = (core_ff.rx_sh[7:1] == DEV_ADDR);
		sticky_set = '0;
		sticky_clr = '0;
		fifo_pop   = 1'b0;
		load_rd    = 1'b0;
		wr_word    = core_ff.ctl[CTL_WR_LO_BIT]
			? {core_ff.rx_sh, core_ff.first_byte}
			: {core_ff.first_byte, core_ff.rx_sh};
		txreq_lvl = core_ff.ctl[CTL_TXREQ_BIT]
			&& (core_ff.st == ST_READ) && fifo_in_ready;
		level_lvl = (core_ff.thr != '0)
			&& (fifo_level >= LW'(core_ff.thr));
		sts = {level_lvl, txreq_lvl, core_ff.sticky};
		case (core_ff.ptr)
			PIN_EN_OFS:    rd_val = core_ff.pin_en;
			PIN_POL_OFS:   rd_val = 16'(core_ff.pin_pol) << PIN_POL_BIT;
			CTL_OFS:       rd_val = 16'(core_ff.ctl);
			THR_OFS:       rd_val = 16'(core_ff.thr) << THR_LSB;
			STATUS_OFS:    rd_val = 16'(sts);
			FIFO_DATA_OFS: rd_val = fifo_out_valid ? fifo_out_data : 16'h0000;
			default:       rd_val = 16'h0000;
		endcase
		if (start_c) begin
			nxt_core.rs_pend        = core_ff.addressed;
			nxt_core.st             = ST_ADDR;
			nxt_core.cnt            = '0;
			nxt_core.sda_drv.drive_n = 1'b1;
		end else if (stop_c) begin
			if (core_ff.addressed) begin
				sticky_set[STS_STOP_BIT] = 1'b1;
			end
			nxt_core.st              = ST_IDLE;
			nxt_core.addressed       = 1'b0;
			nxt_core.rs_pend         = 1'b0;
			nxt_core.sda_drv.drive_n = 1'b1;
		end else if (core_ff.st != ST_IDLE && rise) begin
			if (core_ff.cnt < CNT_DATA_DONE) begin
				nxt_core.rx_sh = {core_ff.rx_sh[6:0], core_ff.sda_s};
				nxt_core.cnt   = core_ff.cnt + 4'h1;
			end else if (core_ff.cnt == CNT_DATA_DONE) begin
				nxt_core.mst_ack = !core_ff.sda_s;
				nxt_core.cnt     = CNT_ACK_DONE;
			end
		end else if (core_ff.st != ST_IDLE && fall) begin
			if (core_ff.cnt == CNT_DATA_DONE) begin
				case (core_ff.st)
					ST_ADDR: begin
						if (addr_hit && core_ff.ctl[CTL_NACK_BIT]) begin
							nxt_core.ctl[CTL_NACK_BIT] = 1'b0;
							nxt_core.st = ST_IGNORE;
						end else if (addr_hit) begin
							nxt_core.sda_drv.drive_n = 1'b0;
							nxt_core.addressed = 1'b1;
							nxt_core.rw = core_ff.rx_sh[0];
							sticky_set[STS_ADDR_BIT] = 1'b1;
							sticky_set[STS_RS_BIT] = core_ff.rs_pend;
						end else begin
							nxt_core.addressed = 1'b0;
							nxt_core.st = ST_IGNORE;
						end
					end
					ST_WRITE: begin
						nxt_core.sda_drv.drive_n = 1'b0;
						if (!core_ff.ptr_valid) begin
							nxt_core.ptr       = core_ff.rx_sh;
							nxt_core.ptr_valid = 1'b1;
							nxt_core.rd_half   = 1'b0;
						end else if (!core_ff.have_first) begin
							nxt_core.first_byte = core_ff.rx_sh;
							nxt_core.have_first = 1'b1;
						end else begin
							nxt_core.have_first = 1'b0;
							case (core_ff.ptr)
								PIN_EN_OFS:  nxt_core.pin_en = wr_word;
								PIN_POL_OFS: nxt_core.pin_pol = wr_word[PIN_POL_BIT];
								CTL_OFS:     nxt_core.ctl = wr_word[CTL_W-1:0];
								THR_OFS:     nxt_core.thr = wr_word[THR_LSB +: THR_W];
								STATUS_OFS:  sticky_clr = wr_word[2:0];
								default:     nxt_core.have_first = 1'b0;
							endcase
						end
					end
					default: nxt_core.sda_drv.drive_n = 1'b1;
				endcase
			end else if (core_ff.cnt == CNT_ACK_DONE) begin
				nxt_core.cnt = '0;
				nxt_core.sda_drv.drive_n = 1'b1;
				if (core_ff.st == ST_ADDR) begin
					nxt_core.st = core_ff.rw ? ST_READ : ST_WRITE;
					nxt_core.ptr_valid  = core_ff.rw ? core_ff.ptr_valid : 1'b0;
					nxt_core.have_first = 1'b0;
					nxt_core.rd_half    = 1'b0;
					load_rd = core_ff.rw;
				end else if (core_ff.st == ST_READ) begin
					if (core_ff.mst_ack) begin
						load_rd = 1'b1;
					end else begin
						nxt_core.st = ST_IGNORE;
					end
				end
			end else if (core_ff.st == ST_READ) begin
				nxt_core.sda_drv.drive_n = core_ff.tx_sh[3'(4'h7 - core_ff.cnt)];
			end
		end
		// A word is fetched when its first byte is due, so a FIFO word is
		// popped once; the phase restarts at every address byte the port acknowledges.
		if (load_rd) begin
			nxt_core.rd_half = ~nxt_core.rd_half;
			if (nxt_core.rd_half) begin
				nxt_core.rd_word = rd_val;
				fifo_pop = (core_ff.ptr == FIFO_DATA_OFS) && fifo_out_valid;
				nxt_core.tx_sh = (core_ff.ptr == FIFO_DATA_OFS
					&& !core_ff.ctl[CTL_FIFO_HI_BIT])
					? rd_val[7:0] : rd_val[15:8];
			end else begin
				nxt_core.tx_sh = (core_ff.ptr == FIFO_DATA_OFS
					&& !core_ff.ctl[CTL_FIFO_HI_BIT])
					? core_ff.rd_word[15:8] : core_ff.rd_word[7:0];
			end
			nxt_core.sda_drv.drive_n = nxt_core.tx_sh[7];
		end
		// Set wins over a clear landing in the same cycle.
		nxt_core.sticky = (core_ff.sticky & ~sticky_clr) | sticky_set;
		en = {(core_ff.thr != '0), core_ff.ctl[CTL_TXREQ_BIT],
			core_ff.ctl[CTL_STOP_IRQ_BIT], core_ff.ctl[CTL_RS_IRQ_BIT],
			core_ff.ctl[CTL_ADDR_IRQ_BIT]};
		irq = |(sts & en);
		nxt_core.int_drv.out = irq ^ core_ff.pin_pol;
		nxt_core.int_drv.drive_n = !(core_ff.pin_en[PIN_OE_BIT]
			&& !core_ff.pin_en[PIN_PMOS_OFF_BIT]);
		nxt_core.sda_drv.out = 1'b0;
		nxt_core.hs = core_ff.ctl[CTL_SPEED_BIT];
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			core_ff                 <= '0;
			core_ff.scl_m           <= 1'b1;
			core_ff.scl_s           <= 1'b1;
			core_ff.scl_d           <= 1'b1;
			core_ff.sda_m           <= 1'b1;
			core_ff.sda_s           <= 1'b1;
			core_ff.sda_d           <= 1'b1;
			core_ff.ctl             <= CTL_RST;
			core_ff.thr             <= THR_RST;
			core_ff.pin_en          <= PIN_EN_RST;
			core_ff.pin_pol         <= PIN_POL_RST;
			core_ff.sda_drv.drive_n <= 1'b1;
			core_ff.int_drv.drive_n <= 1'b1;
		end else begin
			core_ff <= nxt_core;
		end
	end
	assign sda_pin   = core_ff.sda_drv;
	assign int_pin   = core_ff.int_drv;
	assign hs_mode   = core_ff.hs;
	assign smp_ready = link_ff.ready;
endmodule

// [bus_port_control_asserts.sv]
// Port-level assertions for the bus port control, bound to its top.
module bus_port_control_asserts
	import ctl_pkg::*;
(
	input wire logic           clk,
	input wire logic           srst,
	input wire logic           scl_in,
	input wire logic           sda_in,
	input ctl_pkg::pin_drive_t sda_pin,
	input ctl_pkg::pin_drive_t int_pin,
	input wire logic           hs_mode,
	input wire logic           smp_clk,
	input wire logic           smp_srst,
	input ctl_pkg::word_beat_t smp_in,
	input wire logic           smp_ready
);
	property p_rst_out;
		@(posedge clk) disable iff (srst) $fell(srst) |->
			sda_pin.drive_n && int_pin.drive_n && !int_pin.out && !hs_mode;
	endproperty
	property p_sda_od;
		@(posedge clk) disable iff (srst) sda_pin.out == 1'h0;
	endproperty
	property p_sda_scl;
		@(posedge clk) disable iff (srst) !$stable(sda_pin.drive_n) |-> !scl_in;
	endproperty
	// Data may only be pulled once the low phase has reached the port.
	property p_ack_win;
		@(posedge clk) disable iff (srst)
			$fell(sda_pin.drive_n) |-> !scl_in && !$past(scl_in, 2);
	endproperty
	property p_cfg_scl;
		@(posedge clk) disable iff (srst)
			!$stable({hs_mode, int_pin.drive_n}) |-> !scl_in;
	endproperty
	property p_smp_rst;
		@(posedge smp_clk) disable iff (smp_srst)
			$fell(smp_srst) |-> !smp_ready ##1 smp_ready;
	endproperty
	property p_smp_take;
		@(posedge smp_clk) disable iff (smp_srst)
			smp_in.valid && smp_ready |=> !smp_ready;
	endproperty
	property p_smp_hold;
		@(posedge smp_clk) disable iff (smp_srst)
			smp_ready && !smp_in.valid |=> smp_ready;
	endproperty
	a_rst_out: assert property (p_rst_out)
		else $error("outputs not at reset values");
	a_sda_od: assert property (p_sda_od)
		else $error("data pin output value not low");
	a_sda_scl: assert property (p_sda_scl)
		else $error("data pin changed while clock high");
	a_ack_win: assert property (p_ack_win)
		else $error("data pulled too early in low phase");
	a_cfg_scl: assert property (p_cfg_scl)
		else $error("setting changed while clock high");
	a_smp_rst: assert property (p_smp_rst)
		else $error("stream ready wrong after reset");
	a_smp_take: assert property (p_smp_take)
		else $error("stream ready held after handshake");
	a_smp_hold: assert property (p_smp_hold)
		else $error("stream ready dropped while idle");
	c_take: cover property (@(posedge smp_clk) smp_in.valid && smp_ready);
	c_ack: cover property (@(posedge clk) $fell(sda_pin.drive_n));
	c_int: cover property (@(posedge clk) $fell(int_pin.drive_n));
	c_hs: cover property (@(posedge clk) $rose(hs_mode));
endmodule

bind bus_port_control bus_port_control_asserts bus_port_control_asserts_i (
	.clk, .srst, .scl_in, .sda_in, .sda_pin, .int_pin, .hs_mode,
	.smp_clk, .smp_srst, .smp_in, .smp_ready
);

// [i2c_host_model.sv]
// Behavioural bus host that drives clock and data toward the port.
module i2c_host_model #(
	parameter logic [6:0] ADDR = 7'h2A
) (
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 1ns;
	// Data moves mid-low so both lines never change in one sync sample.
	localparam int H = 300;
	initial begin
		scl = 1'h1;
		sda_drv = 1'h1;
	end
	task automatic bit_io(input logic b, output logic r);
		#H sda_drv = b;
		#H scl = 1'h1;
		#(2*H) r = sda;
		scl = 1'h0;
	endtask
	task automatic xbyte(input logic [7:0] d, input logic ab,
			output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(ab, ack);
	endtask
	task automatic start();
		#H sda_drv = 1'h1;
		#H scl = 1'h1;
		#(2*H) sda_drv = 1'h0;
		#(2*H) scl = 1'h0;
	endtask
	task automatic stop();
		#H sda_drv = 1'h0;
		#H scl = 1'h1;
		#(2*H) sda_drv = 1'h1;
		#(2*H);
	endtask
	// Payload bytes pass unchanged; callers keep reserved bits zero.
	task automatic wr(input logic [7:0] p, b1, b2, output logic nak);
		logic [7:0] q;
		logic [3:0] a;
		start();
		xbyte({ADDR, 1'h0}, 1'h1, q, a[0]);
		xbyte(p, 1'h1, q, a[1]);
		xbyte(b1, 1'h1, q, a[2]);
		xbyte(b2, 1'h1, q, a[3]);
		stop();
		nak = |a;
	endtask
	task automatic rd(input logic [7:0] p, output logic [15:0] v);
		logic [7:0] q;
		logic       a;
		start();
		xbyte({ADDR, 1'h0}, 1'h1, q, a);
		xbyte(p, 1'h1, q, a);
		start();
		xbyte({ADDR, 1'h1}, 1'h1, q, a);
		xbyte(8'hFF, 1'h0, v[15:8], a);
		xbyte(8'hFF, 1'h1, v[7:0], a);
		stop();
	endtask
endmodule

// [bus_port_control_bench.sv]
// Self-checking bench for the bus port control.
module bus_port_control_bench
	import ctl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk = 1'h0;
	logic       srst = 1'h1;
	logic       smp_clk = 1'h0;
	logic       smp_srst = 1'h1;
	word_beat_t smp_in = '0;
	logic       scl;
	logic       sda_drv;
	logic       sda;
	pin_drive_t sda_pin;
	pin_drive_t int_pin;
	logic       hs_mode;
	logic       smp_ready;
	int         n_errors = 0;
	int         total_checks = 0;
	int         cyc = 0;
	// Pull-up on the data line: low only when a party pulls it down.
	assign sda = sda_drv & sda_pin.drive_n;
	always #50 clk = ~clk;
	always #80 smp_clk = ~smp_clk;
	bus_port_control bus_port_control_i (.clk, .srst, .scl_in(scl),
		.sda_in(sda), .sda_pin, .int_pin, .hs_mode, .smp_clk, .smp_srst,
		.smp_in, .smp_ready);
	i2c_host_model #(.ADDR(DEV_ADDR_DEF)) i2c_host_model_i (.scl,
		.sda_drv, .sda);
	task automatic check(string nm, logic [15:0] s, logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// The run needs about 25k cycles; the ceiling leaves ample margin.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			end_sim();
		end
	end
	task automatic wr(logic [7:0] p, logic [15:0] v, logic lo);
		logic nak;
		@(posedge clk) #1;
		i2c_host_model_i.wr(p, lo ? v[7:0] : v[15:8], lo ? v[15:8] : v[7:0],
			nak);
		check("ack", 16'(nak), 16'h0000);
	endtask
	task automatic rchk(string nm, logic [7:0] p, logic [15:0] m,
			logic [15:0] e);
		logic [15:0] v;
		@(posedge clk) #1;
		i2c_host_model_i.rd(p, v);
		check(nm, v & m, e);
	endtask
	// Ready is read a step after the edge, once it has settled; the word
	// then stands until the next edge, where ready is still high.
	task automatic wait_rdy();
		int k = 0;
		do begin
			@(posedge smp_clk) #1;
			k++;
		end while (smp_ready !== 1'h1 && k < 100);
	endtask
	task automatic push(logic [15:0] d);
		wait_rdy();
		smp_in = '{valid: 1'h1, data: d};
		@(posedge smp_clk);
		#1 smp_in.valid = 1'h0;
	endtask
	task automatic t_reset();
		rchk("ctl", CTL_OFS, 16'hFFFF, 16'h0001);
		rchk("thr", THR_OFS, 16'hFFFF, 16'h0000);
		check("hs", 16'(hs_mode), 16'h0000);
		check("int_oe", 16'(int_pin.drive_n), 16'h0001);
	endtask
	task automatic t_order();
		wr(CTL_OFS, 16'h1401, 1'h0);
		check("hs", 16'(hs_mode), 16'h0001);
		rchk("ctl", CTL_OFS, 16'hFFFF, 16'h1401);
		wr(CTL_OFS, 16'h0001, 1'h1);
		check("hs", 16'(hs_mode), 16'h0000);
		rchk("ctl", CTL_OFS, 16'hFFFF, 16'h0001);
	endtask
	task automatic t_nack();
		logic nak;
		wr(CTL_OFS, 16'h0009, 1'h0);
		@(posedge clk) #1;
		i2c_host_model_i.wr(CTL_OFS, 8'h00, 8'h03, nak);
		check("nack", 16'(nak), 16'h0001);
		rchk("ctl", CTL_OFS, 16'hFFFF, 16'h0001);
	endtask
	task automatic t_irq();
		logic [15:0] cv [4] = '{16'h0001, 16'h0003, 16'h0011, 16'h0005};
		logic        ex [4] = '{1'h0, 1'h1, 1'h1, 1'h0};
		wr(PIN_EN_OFS, 16'h0004, 1'h0);
		wr(STATUS_OFS, 16'h0007, 1'h0);
		for (int i = 0; i < 4; i++) begin
			wr(CTL_OFS, cv[i], 1'h0);
			check("irq", 16'(int_pin.out), 16'(ex[i]));
		end
		rchk("ctl", CTL_OFS, 16'hFFFF, 16'h0005);
		check("rs_irq", 16'(int_pin.out), 16'h0001);
		check("drive", 16'(int_pin.drive_n), 16'h0000);
		wr(PIN_POL_OFS, 16'h0020, 1'h0);
		check("pol", 16'(int_pin.out), 16'h0000);
		wr(CTL_OFS, 16'h0001, 1'h0);
		check("pol_idle", 16'(int_pin.out), 16'h0001);
		wr(PIN_EN_OFS, 16'h0000, 1'h0);
		check("off", 16'(int_pin.drive_n), 16'h0001);
		wr(PIN_POL_OFS, 16'h0000, 1'h0);
	endtask
	task automatic t_fifo();
		wr(THR_OFS, 16'h0200, 1'h0);
		push(16'h1234);
		push(16'hABCD);
		wait_rdy();
		rchk("lvl2", STATUS_OFS, 16'h0010, 16'h0010);
		rchk("lo_first", FIFO_DATA_OFS, 16'hFFFF, 16'h3412);
		rchk("lvl1", STATUS_OFS, 16'h0010, 16'h0000);
		wr(CTL_OFS, 16'h0081, 1'h0);
		rchk("hi_first", FIFO_DATA_OFS, 16'hFFFF, 16'hABCD);
		for (int i = 0; i < FIFO_DEPTH_DEF; i++)
			push(16'h0100 + 16'(i));
		// One more word parks in the crossing stage; ready must then stay
		// low until the host frees a FIFO entry.
		push(16'hFFFF);
		repeat (8) begin
			@(posedge smp_clk) #1;
			check("full", 16'(smp_ready), 16'h0000);
		end
		for (int i = 0; i < FIFO_DEPTH_DEF; i++)
			rchk("drain", FIFO_DATA_OFS, 16'hFFFF, 16'h0100 + 16'(i));
		rchk("spill", FIFO_DATA_OFS, 16'hFFFF, 16'hFFFF);
		rchk("empty", FIFO_DATA_OFS, 16'hFFFF, 16'h0000);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		#1 srst = 1'h0;
		@(posedge smp_clk);
		#1 smp_srst = 1'h0;
		repeat (4) @(posedge clk);
		t_reset();
		t_order();
		t_nack();
		t_irq();
		t_fifo();
		end_sim();
	end
endmodule
